// ---- rtl/pspm_defs.vh ----
// Constants for the pulse and semi-period measurement block
`ifndef PSPM_DEFS_VH
`define PSPM_DEFS_VH

// Register offsets
`define PSPM_OFS_CTRL 8'h00
`define PSPM_OFS_ARM 8'h04
`define PSPM_OFS_STATUS 8'h08
`define PSPM_OFS_DATA 8'h0C
`define PSPM_OFS_LAST_HI 8'h10
`define PSPM_OFS_LAST_LO 8'h14

// Control field positions
`define PSPM_CTRL_MODE_LSB 0
`define PSPM_CTRL_TIMING_LSB 2
`define PSPM_CTRL_GATE_LVL 4
`define PSPM_CTRL_SRC_FALL 5
`define PSPM_CTRL_SAMP_FALL 6
`define PSPM_CTRL_FIRST_HIGH 7
`define PSPM_CTRL_DMA_EN 8
`define PSPM_CTRL_W 9
`define PSPM_CTRL_RESET 9'h090

// Arm register bits
`define PSPM_ARM_GO 0
`define PSPM_ARM_STOP 1

// Status field positions
`define PSPM_STAT_ARMED 0
`define PSPM_STAT_DONE 1
`define PSPM_STAT_OVERRUN 2
`define PSPM_STAT_OVERFLOW 3
`define PSPM_STAT_LEVEL_LSB 8

// Measurement modes
`define PSPM_MODE_WIDTH 2'h0
`define PSPM_MODE_PULSE 2'h1
`define PSPM_MODE_SEMI 2'h2

// Timing kinds
`define PSPM_TIM_SINGLE 2'h0
`define PSPM_TIM_IMPLICIT 2'h1
`define PSPM_TIM_SAMPLED 2'h2
`define PSPM_TIM_HARDWARE_TIMED_SINGLE_POINT 2'h3

// Sizes
`define PSPM_CNT_W 32
`define PSPM_FIFO_DEPTH 16
`define PSPM_FIFO_AW 4
`define PSPM_FIFO_FULL 5'h10

`endif

// ---- rtl/pspm_fifo.v ----
// Counter FIFO with a registered head word
`include "pspm_defs.vh"

module pspm_fifo (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Fill side
  input wire i_push,
  input wire [31:0] i_data,
  // Drain side
  input wire i_pop,
  output reg o_valid,
  output reg [31:0] o_data,
  // Level
  output wire o_full,
  output wire [4:0] o_count
);

  reg [31:0] mem [0:`PSPM_FIFO_DEPTH-1];
  reg [`PSPM_FIFO_AW-1:0] wr_ptr_reg;
  reg [`PSPM_FIFO_AW-1:0] rd_ptr_reg;
  reg [4:0] fill_reg;
  wire take;
  wire load;
  wire wr;

  assign o_full = (fill_reg == `PSPM_FIFO_FULL);
  assign take = o_valid & i_pop;
  assign load = (fill_reg != 5'h00) & (~o_valid | take);
  assign wr = i_push & ~o_full;
  assign o_count = fill_reg + {4'h0, o_valid};

  always @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      fill_reg <= 5'h00;
      o_valid <= 1'b0;
      o_data <= 32'h00000000;
    end else begin
      if (wr) begin
        mem[wr_ptr_reg] <= i_data;
        wr_ptr_reg <= wr_ptr_reg + 4'h1;
      end
      if (load) begin
        o_data <= mem[rd_ptr_reg];
        rd_ptr_reg <= rd_ptr_reg + 4'h1;
      end
      if (wr & ~load) begin
        fill_reg <= fill_reg + 5'h01;
      end else if (load & ~wr) begin
        fill_reg <= fill_reg - 5'h01;
      end
      o_valid <= load | (o_valid & ~take);
    end
  end

endmodule // pspm_fifo

// ---- rtl/pspm_top.v ----
// Pulse-width, pulse and semi-period measurement counter
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`include "pspm_defs.vh"

module pspm_top (
  // Clock and reset
  input wire I_MCLK,
  input wire I_SRST,
  // Register port
  input wire [7:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [31:0] O_RDATA,
  // Measured signals
  input wire I_GATE,
  input wire I_SOURCE,
  input wire I_SAMPLE_CLK,
  // DMA port
  output wire O_DMA_REQ,
  output wire [31:0] O_DMA_DATA,
  input wire I_DMA_ACK,
  // Status
  output reg O_OVERRUN
);

  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_RUN = 2'h2;
  localparam ST_DONE = 2'h3;

  // Edge of the selected polarity
  function edge_hit;
    input cur;
    input prev;
    input fall;
    begin
      edge_hit = fall ? (prev & ~cur) : (cur & ~prev);
    end
  endfunction

  // Register strobe at a given offset
  function reg_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      reg_hit = strobe & (addr == ofs);
    end
  endfunction

  reg [`PSPM_CTRL_W-1:0] ctrl_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [31:0] cnt_reg;
  reg [31:0] cnt_next;
  reg phase_reg;
  reg phase_next;
  reg [31:0] first_reg;
  reg [31:0] first_next;
  reg [31:0] last_hi_reg;
  reg [31:0] last_hi_next;
  reg [31:0] last_lo_reg;
  reg [31:0] last_lo_next;
  reg last_valid_reg;
  reg last_valid_next;
  reg fresh_reg;
  reg fresh_next;
  reg pend_reg;
  reg pend_next;
  reg [31:0] pend_data_reg;
  reg [31:0] pend_data_next;
  reg overflow_reg;
  reg gate_prev_reg;
  reg src_prev_reg;
  reg samp_prev_reg;
  reg push;
  reg [31:0] push_data;
  reg overrun_set;
  reg comp;

  wire [1:0] mode;
  wire [1:0] timing;
  wire gate_lvl;
  wire src_fall;
  wire samp_fall;
  wire first_high;
  wire dma_en;
  wire [1:0] eff_mode;
  wire [1:0] eff_timing;
  wire is_width;
  wire sampled;
  wire src_tick;
  wire samp_tick;
  wire gate_lead;
  wire gate_trail;
  wire gate_any;
  wire start_edge;
  wire gate_act;
  wire [31:0] cnt_inc;
  wire [31:0] tick_cnt;
  wire wr_ctrl;
  wire wr_arm;
  wire wr_stat;
  wire rd_data;
  wire fifo_valid;
  wire fifo_full;
  wire fifo_pop;
  wire [31:0] fifo_data;
  wire [4:0] fifo_count;

  assign mode = ctrl_reg[`PSPM_CTRL_MODE_LSB +: 2];
  assign timing = ctrl_reg[`PSPM_CTRL_TIMING_LSB +: 2];
  assign gate_lvl = ctrl_reg[`PSPM_CTRL_GATE_LVL];
  assign src_fall = ctrl_reg[`PSPM_CTRL_SRC_FALL];
  assign samp_fall = ctrl_reg[`PSPM_CTRL_SAMP_FALL];
  assign first_high = ctrl_reg[`PSPM_CTRL_FIRST_HIGH];
  assign dma_en = ctrl_reg[`PSPM_CTRL_DMA_EN];

  // Single semi-period runs as single width; semi-period never sampled
  assign eff_mode = (mode == `PSPM_MODE_SEMI && timing == `PSPM_TIM_SINGLE) ? `PSPM_MODE_WIDTH : mode;
  assign eff_timing = (mode == `PSPM_MODE_SEMI && timing[1]) ? `PSPM_TIM_IMPLICIT : timing;
  assign is_width = (eff_mode == `PSPM_MODE_WIDTH) || (eff_mode == 2'h3);
  assign sampled = eff_timing[1];

  // Edge detection on the synchronous inputs
  assign src_tick = edge_hit(I_SOURCE, src_prev_reg, src_fall);
  assign samp_tick = edge_hit(I_SAMPLE_CLK, samp_prev_reg, samp_fall);
  assign gate_lead = edge_hit(I_GATE, gate_prev_reg, ~gate_lvl);
  assign gate_trail = edge_hit(I_GATE, gate_prev_reg, gate_lvl);
  assign gate_any = I_GATE ^ gate_prev_reg;
  assign start_edge = edge_hit(I_GATE, gate_prev_reg, ~first_high);
  assign gate_act = (I_GATE == gate_lvl);
  assign cnt_inc = cnt_reg + {31'h0, src_tick};
  assign tick_cnt = {31'h0, src_tick};

  // Register decode
  assign wr_ctrl = reg_hit(I_WR, I_ADDR, `PSPM_OFS_CTRL);
  assign wr_arm = reg_hit(I_WR, I_ADDR, `PSPM_OFS_ARM);
  assign wr_stat = reg_hit(I_WR, I_ADDR, `PSPM_OFS_STATUS);
  assign rd_data = reg_hit(I_RD, I_ADDR, `PSPM_OFS_DATA);
  assign fifo_pop = dma_en ? I_DMA_ACK : rd_data;

  // Measurement engine
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    phase_next = phase_reg;
    first_next = first_reg;
    last_hi_next = last_hi_reg;
    last_lo_next = last_lo_reg;
    last_valid_next = last_valid_reg;
    fresh_next = fresh_reg;
    pend_next = 1'b0;
    pend_data_next = pend_data_reg;
    push = 1'b0;
    push_data = 32'h00000000;
    overrun_set = 1'b0;
    comp = 1'b0;
    if (pend_reg) begin
      push = 1'b1;
      push_data = pend_data_reg;
    end
    case (state_reg)
      ST_IDLE: begin
        cnt_next = 32'h00000000;
      end
      ST_WAIT: begin
        if (is_width) begin
          if (gate_lead) begin
            state_next = ST_RUN;
            cnt_next = tick_cnt;
          end
        end else if (start_edge) begin
          state_next = ST_RUN;
          cnt_next = tick_cnt;
          phase_next = 1'b0;
        end
      end
      ST_RUN: begin
        if (is_width) begin
          cnt_next = gate_act ? cnt_inc : 32'h00000000;
          if (gate_trail) begin
            if (eff_timing == `PSPM_TIM_SINGLE) begin
              push = 1'b1;
              push_data = cnt_reg;
              state_next = ST_DONE;
            end else if (sampled) begin
              last_hi_next = cnt_reg;
              last_valid_next = 1'b1;
              comp = 1'b1;
            end else begin
              push = 1'b1;
              push_data = cnt_reg;
            end
          end
        end else if (gate_any) begin
          cnt_next = tick_cnt;
          phase_next = ~phase_reg;
          if (sampled) begin
            if (!phase_reg) begin
              first_next = cnt_reg;
            end else begin
              last_hi_next = first_high ? first_reg : cnt_reg;
              last_lo_next = first_high ? cnt_reg : first_reg;
              last_valid_next = 1'b1;
              comp = 1'b1;
            end
          end else begin
            push = 1'b1;
            push_data = cnt_reg;
            if (eff_timing == `PSPM_TIM_SINGLE && phase_reg) begin
              state_next = ST_DONE;
            end
          end
        end else begin
          cnt_next = cnt_inc;
        end
      end
      ST_DONE: begin
        cnt_next = cnt_reg;
      end
      default: begin
        cnt_next = cnt_reg;
      end
    endcase
    // Sample clock handling
    if (sampled && (state_reg == ST_WAIT || state_reg == ST_RUN) && samp_tick) begin
      if (eff_timing == `PSPM_TIM_HARDWARE_TIMED_SINGLE_POINT && !(fresh_reg || comp)) begin
        overrun_set = 1'b1;
      end
      if (last_valid_next) begin
        push = 1'b1;
        push_data = last_hi_next;
        if (!is_width) begin
          pend_next = 1'b1;
          pend_data_next = last_lo_next;
        end
      end
      fresh_next = 1'b0;
    end else if (comp) begin
      fresh_next = 1'b1;
    end
    // Arm and disarm from software
    if (wr_arm && I_WDATA[`PSPM_ARM_STOP]) begin
      state_next = ST_IDLE;
    end else if (wr_arm && I_WDATA[`PSPM_ARM_GO]) begin
      state_next = ST_WAIT;
      cnt_next = 32'h00000000;
      phase_next = 1'b0;
      last_valid_next = 1'b0;
      fresh_next = 1'b0;
    end
  end

  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      ctrl_reg <= `PSPM_CTRL_RESET;
      state_reg <= ST_IDLE;
      cnt_reg <= 32'h00000000;
      phase_reg <= 1'b0;
      first_reg <= 32'h00000000;
      last_hi_reg <= 32'h00000000;
      last_lo_reg <= 32'h00000000;
      last_valid_reg <= 1'b0;
      fresh_reg <= 1'b0;
      pend_reg <= 1'b0;
      pend_data_reg <= 32'h00000000;
      overflow_reg <= 1'b0;
      O_OVERRUN <= 1'b0;
      gate_prev_reg <= 1'b0;
      src_prev_reg <= 1'b0;
      samp_prev_reg <= 1'b0;
      O_RDATA <= 32'h00000000;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= I_WDATA[`PSPM_CTRL_W-1:0];
      end
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
      first_reg <= first_next;
      last_hi_reg <= last_hi_next;
      last_lo_reg <= last_lo_next;
      last_valid_reg <= last_valid_next;
      fresh_reg <= fresh_next;
      pend_reg <= pend_next;
      pend_data_reg <= pend_data_next;
      gate_prev_reg <= I_GATE;
      src_prev_reg <= I_SOURCE;
      samp_prev_reg <= I_SAMPLE_CLK;
      // Sticky flags: a new event wins over a clear
      O_OVERRUN <= overrun_set | (O_OVERRUN & ~(wr_stat & I_WDATA[`PSPM_STAT_OVERRUN]));
      overflow_reg <= (push & fifo_full) | (overflow_reg & ~(wr_stat & I_WDATA[`PSPM_STAT_OVERFLOW]));
      if (I_RD) begin
        case (I_ADDR)
          `PSPM_OFS_CTRL: O_RDATA <= {23'h0, ctrl_reg};
          `PSPM_OFS_STATUS: O_RDATA <= {19'h0, fifo_count, 4'h0, overflow_reg, O_OVERRUN,
                                        (state_reg == ST_DONE), (state_reg == ST_WAIT || state_reg == ST_RUN)};
          `PSPM_OFS_DATA: O_RDATA <= fifo_valid ? fifo_data : 32'h00000000;
          `PSPM_OFS_LAST_HI: O_RDATA <= last_hi_reg;
          `PSPM_OFS_LAST_LO: O_RDATA <= last_lo_reg;
          default: O_RDATA <= 32'h00000000;
        endcase
      end else begin
        O_RDATA <= 32'h00000000;
      end
    end
  end

  // Counter FIFO, drained by DMA or by software reads
  pspm_fifo u_fifo (
    .i_clk(I_MCLK),
    .i_rst(I_SRST),
    .i_push(push),
    .i_data(push_data),
    .i_pop(fifo_pop),
    .o_valid(fifo_valid),
    .o_data(fifo_data),
    .o_full(fifo_full),
    .o_count(fifo_count)
  );

  assign O_DMA_REQ = fifo_valid;
  assign O_DMA_DATA = fifo_data;

endmodule // pspm_top

// ---- sim/pspm_top_asserts.sv ----
// Port assertions for the measurement counter
module pspm_top_asserts (
  // Clock and reset
  input wire I_MCLK,
  input wire I_SRST,
  // Register port
  input wire [7:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  input wire [31:0] O_RDATA,
  // Measured signals
  input wire I_GATE,
  input wire I_SOURCE,
  input wire I_SAMPLE_CLK,
  // DMA port and status
  input wire O_DMA_REQ,
  input wire [31:0] O_DMA_DATA,
  input wire I_DMA_ACK,
  input wire O_OVERRUN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic gate_d, samp_d;
  logic [5:0] g_h, s_h, a_h;
  // Recent gate, sample and pop activity
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      gate_d <= 1'b0;
      samp_d <= 1'b0;
      g_h <= 6'h0;
      s_h <= 6'h0;
      a_h <= 6'h0;
    end else begin
      gate_d <= I_GATE;
      samp_d <= I_SAMPLE_CLK;
      g_h <= {g_h[4:0], I_GATE != gate_d};
      s_h <= {s_h[4:0], I_SAMPLE_CLK != samp_d};
      a_h <= {a_h[4:0], I_DMA_ACK};
    end
  end
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_SRST);
  a_reset_clear: assert property (disable iff (1'b0) I_SRST |=> O_RDATA == 32'h0 && !O_DMA_REQ && !O_OVERRUN)
    else $error("Outputs not cleared by reset");
  a_read_idle: assert property (!I_RD |=> O_RDATA == 32'h0)
    else $error("Read data outside answer cycle");
  a_unmapped_zero: assert property (I_RD && I_ADDR == 8'hFC |=> O_RDATA == 32'h0)
    else $error("Unmapped read not zero");
  a_ctrl_readback: assert property (I_WR && I_ADDR == 8'h00 ##1 !I_WR ##1 I_RD && I_ADDR == 8'h00
    |=> O_RDATA[8:0] == $past(I_WDATA[8:0], 3))
    else $error("Control readback differs");
  a_push_cause: assert property ($rose(O_DMA_REQ) |-> (|g_h) || (|s_h) || (|a_h))
    else $error("Word pushed without gate or sample edge");
  a_head_holds: assert property (O_DMA_REQ && !I_DMA_ACK && !(I_RD && I_ADDR == 8'h0C)
    |=> O_DMA_REQ && $stable(O_DMA_DATA))
    else $error("Head word lost without pop");
  a_overrun_cause: assert property ($rose(O_OVERRUN) |-> |s_h)
    else $error("Overrun without sample edge");
  a_overrun_sticky: assert property (O_OVERRUN && !(I_WR && I_ADDR == 8'h08 && I_WDATA[2]) |=> O_OVERRUN)
    else $error("Overrun dropped without clear");
  c_pop: cover property (O_DMA_REQ && I_DMA_ACK);
  c_overrun: cover property ($rose(O_OVERRUN));
  c_unmapped: cover property (I_RD && I_ADDR == 8'hFC);
endmodule // pspm_top_asserts

bind pspm_top pspm_top_asserts u_chk (.I_MCLK, .I_SRST, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_GATE,
  .I_SOURCE, .I_SAMPLE_CLK, .O_DMA_REQ, .O_DMA_DATA, .I_DMA_ACK, .O_OVERRUN);

// ---- sim/pspm_far_model.sv ----
// Far side model: gate driver, timebase and DMA controller
module pspm_far_model (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Measured signals
  output logic o_gate,
  output logic o_source,
  // DMA handshake
  input wire i_stall,
  input wire i_req,
  input wire [31:0] i_data,
  output logic o_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] words[$];
  initial begin
    o_gate = 1'b0;
    o_source = 1'b0;
    o_ack = 1'b0;
  end
  // Timebase ticks every second cycle; one pop per two cycles
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_source <= 1'b0;
      o_ack <= 1'b0;
    end else begin
      o_source <= ~o_source;
      o_ack <= i_req && !o_ack && !i_stall;
      if (o_ack) words.push_back(i_data);
    end
  end
  // Hold the gate at a level for n cycles
  task automatic drive(input logic lvl, input int n);
    @(posedge i_clk);
    o_gate <= lvl;
    repeat (n - 1) @(posedge i_clk);
  endtask
endmodule // pspm_far_model

// ---- sim/tb_pspm_top.sv ----
// Testbench for the measurement counter
`include "pspm_defs.vh"
module tb_pspm_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic samp = 1'b0;
  logic stall = 1'b0;
  wire gate, src, req, ack, ovr;
  wire [31:0] rdata, dma_data;
  int n_mismatch = 0;
  int compares = 0;

  always #25 mclk = ~mclk;

  pspm_top dut (.I_MCLK(mclk), .I_SRST(srst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_GATE(gate), .I_SOURCE(src), .I_SAMPLE_CLK(samp), .O_DMA_REQ(req),
    .O_DMA_DATA(dma_data), .I_DMA_ACK(ack), .O_OVERRUN(ovr));
  pspm_far_model far (.i_clk(mclk), .i_rst(srst), .o_gate(gate), .o_source(src), .i_stall(stall),
    .i_req(req), .i_data(dma_data), .o_ack(ack));

  task automatic final_report();
    $display("Compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrt(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic start(input logic [31:0] c);
    wrt(`PSPM_OFS_ARM, 32'h2);
    wrt(`PSPM_OFS_CTRL, c);
    wrt(`PSPM_OFS_ARM, 32'h1);
  endtask
  task automatic wave(input logic lvl, input int d[$]);
    foreach (d[i]) far.drive(lvl ^ (i % 2 == 1), d[i]);
  endtask
  task automatic samp_edge();
    @(posedge mclk);
    samp <= 1'b1;
    repeat (2) @(posedge mclk);
    samp <= 1'b0;
  endtask
  // Wait for the words, then compare count and contents
  task automatic expect_words(input logic [31:0] e[$]);
    int k;
    k = 0;
    while (far.words.size() < e.size() && k < 200) begin
      @(posedge mclk);
      k++;
    end
    repeat (8) @(posedge mclk);
    chk(32'(far.words.size()), 32'(e.size()));
    foreach (e[i]) if (i < far.words.size()) chk(far.words[i], e[i]);
    far.words.delete();
    if (k == 200) begin
      n_mismatch++;
      final_report();
    end
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    rdc(`PSPM_OFS_CTRL, 32'h90);
    rdc(`PSPM_OFS_STATUS, 32'h0);
    rdc(8'hFC, 32'h0);
    chk({31'h0, req}, 32'h0);
    // Width, high active, armed inside a pulse
    wave(1'b1, '{2});
    wrt(`PSPM_OFS_CTRL, 32'h114);
    rdc(`PSPM_OFS_CTRL, 32'h114);
    wrt(`PSPM_OFS_ARM, 32'h1);
    wave(1'b1, '{6, 4, 8, 4, 4, 4});
    expect_words('{4, 2});
    // Width, low active
    start(32'h104);
    wave(1'b0, '{4, 2, 6, 4});
    expect_words('{3});
    // Pulse, high first, DMA stalled meanwhile
    start(32'h195);
    stall <= 1'b1;
    wave(1'b1, '{4, 4, 8, 6, 4, 4});
    stall <= 1'b0;
    expect_words('{4, 3, 2});
    // Semi-period, low first
    start(32'h116);
    wave(1'b0, '{2, 4, 6, 8, 2, 4});
    expect_words('{3, 4, 1});
    // Single width stores once
    start(32'h110);
    wave(1'b1, '{2, 2, 6, 4, 8, 4});
    expect_words('{3});
    rdc(`PSPM_OFS_STATUS, 32'h2);
    // Sampled pulse
    start(32'h199);
    samp_edge();
    wave(1'b0, '{2, 6, 4, 2});
    samp_edge();
    samp_edge();
    expect_words('{3, 2, 3, 2});
    rdc(`PSPM_OFS_LAST_HI, 32'h3);
    rdc(`PSPM_OFS_LAST_LO, 32'h2);
    // Single point width with overrun
    start(32'h11C);
    wave(1'b1, '{2, 4, 4, 2});
    samp_edge();
    repeat (4) @(posedge mclk);
    chk({31'h0, ovr}, 32'h0);
    samp_edge();
    expect_words('{2, 2});
    chk({31'h0, ovr}, 32'h1);
    rdc(`PSPM_OFS_STATUS, 32'h5);
    wrt(`PSPM_OFS_STATUS, 32'h4);
    rdc(`PSPM_OFS_STATUS, 32'h1);
    // Single pulse, high first, falling source edges
    start(32'h1B1);
    wave(1'b0, '{2, 6, 4, 8, 2});
    expect_words('{3, 2});
    rdc(`PSPM_OFS_STATUS, 32'h2);
    // Semi-period asked for sample clock runs implicit
    start(32'h11A);
    samp_edge();
    wave(1'b0, '{2, 4, 6, 2});
    expect_words('{3});
    // Single semi-period acts as single width
    start(32'h112);
    wave(1'b1, '{2, 2, 4, 2});
    expect_words('{2});
    rdc(`PSPM_OFS_STATUS, 32'h2);
    final_report();
  end
endmodule // tb_pspm_top
